// ### core/sgc_pkg.sv
// package: constants for the stereo gain serial control block
package sgc_pkg;
    localparam int SGC_WORD_BITS = 16;
    localparam int SGC_CODE_BITS = 8;
    localparam logic [7:0] SGC_GAIN_RESET = 8'h00;
    localparam logic [7:0] SGC_GAIN_MUTE = 8'h00;
    localparam int SGC_CLK_MHZ = 250;
    localparam int SGC_ZC_TIMEOUT_MS = 16;
    localparam int SGC_ZC_TIMEOUT_CYC = SGC_ZC_TIMEOUT_MS * SGC_CLK_MHZ * 1000;
    localparam int SGC_ZC_CROSSINGS = 2;
    localparam int SGC_RIGHT_MSB = 15;
    localparam int SGC_LEFT_MSB = 7;
endpackage

// ### core/sgc_top.sv
// top: serial gain word receiver, daisy-chain output, gain codes
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////
// Contract
// (R01) data accepted only while select is low
// (R02) word is 16 bits, two 8-bit gains
// (R03) msb first, unsigned binary codes
// (R04) sample serial input on clock rise
// (R05) serial out driven only while selected
// (R06) serial out changes after clock fall
// (R07) serial out passes shifted bits onward
// (R08) power-up: all cleared, both codes zero
// (R09) codes hold until a new write
// (R10) right and left codes held separately
// (R11) code zero mutes that channel
// (R12) gain dB = 31.5 - 0.5*(255-N)
// (R13) apply with or without zero crossing
// (R14) zero-cross enable is active high
// (R15) mute input is active low
// (R16) host holds mute low at least 2 ms
// (R17) two crossings or 16 ms, else direct
// (R18) mute after crossing; waits for deselect
// (R19) chain: select low 16 times N clocks
// (R20) load codes on select rising edge only
// (R21) right byte first, then left byte
// (R22) per-channel sign input and timebase
module sgc_top
    import sgc_pkg::*;
#(
    parameter int TIMEOUT_CYC = SGC_ZC_TIMEOUT_CYC
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // serial port pins
    input wire logic sel_n,
    input wire logic shift_clk,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_oe_n,
    // control pins
    input wire logic zero_cross_enable,
    input wire logic mute_n,
    // analog path signs
    input wire logic right_sign,
    input wire logic left_sign,
    // to the analog switch array
    output logic [7:0] right_gain,
    output logic [7:0] left_gain,
    output logic right_analog_ground,
    output logic left_analog_ground
);
    //////////////////////////////////////////////////////////////////
    // the shifter must split into exactly the right and left codes
    if (SGC_WORD_BITS != 2 * SGC_CODE_BITS)
    begin : g_word_chk
        $error("word must hold two gain codes");
    end
    if (TIMEOUT_CYC < 2)
    begin : g_tmo_chk
        $error("timeout too short");
    end
    //////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [1:0] sel_sy;
        logic [1:0] clk_sy;
        logic [1:0] din_sy;
        logic [1:0] zc_sy;
        logic [1:0] mute_sy;
        logic clk_d;
        logic sel_d;
        logic [15:0] shreg;
        logic [7:0] right_code;
        logic [7:0] left_code;
        logic mute_lat;
        logic dout;
        logic oe_n;
        logic [7:0] r_out;
        logic [7:0] l_out;
        logic r_gnd;
        logic l_gnd;
    } sgc_top_s;

    sgc_top_s st, next_st;
    logic sel_now, clk_rise, clk_fall, sel_rise;
    logic [7:0] r_act, l_act;

    function automatic logic is_mute(input logic [7:0] code);
        return code == SGC_GAIN_MUTE;
    endfunction

    function automatic logic is_rise(input logic now, input logic was);
        return now && !was;
    endfunction

    // select, clock, data, zero-cross and mute pins go through two flops; only stage two is read
    assign sel_now = st.sel_sy[1];
    assign clk_rise = is_rise(st.clk_sy[1], st.clk_d);
    assign clk_fall = is_rise(!st.clk_sy[1], !st.clk_d);
    assign sel_rise = is_rise(sel_now, st.sel_d);

    always_comb
    begin
        next_st = st;
        next_st.sel_sy = {st.sel_sy[0], sel_n};
        next_st.clk_sy = {st.clk_sy[0], shift_clk};
        next_st.din_sy = {st.din_sy[0], serial_in};
        next_st.zc_sy = {st.zc_sy[0], zero_cross_enable};
        next_st.mute_sy = {st.mute_sy[0], mute_n};
        next_st.clk_d = st.clk_sy[1];
        next_st.sel_d = sel_now;
        if (!sel_now && clk_rise) // R01 R04
            next_st.shreg = {st.shreg[14:0], st.din_sy[1]}; // R03
        if (!sel_now && clk_fall)
            next_st.dout = st.shreg[SGC_WORD_BITS - 1]; // R06 R07
        next_st.oe_n = sel_now; // R05
        if (sel_rise)
        begin
            next_st.right_code = st.shreg[SGC_RIGHT_MSB -: SGC_CODE_BITS]; // R20 R21 R02
            next_st.left_code = st.shreg[SGC_LEFT_MSB -: SGC_CODE_BITS]; // R10
        end
        // mute low is only taken while deselected; release follows at once
        if (!st.mute_sy[1] && sel_now) // R15 R18
            next_st.mute_lat = 1'b1;
        else if (st.mute_sy[1])
            next_st.mute_lat = 1'b0;
        // switch array decodes gain as 31.5 - 0.5*(255-N) dB
        next_st.r_out = r_act; // R12
        next_st.l_out = l_act;
        next_st.r_gnd = is_mute(r_act); // R11
        next_st.l_gnd = is_mute(l_act);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st <= '0; // R08
            st.sel_sy <= 2'h3;
            st.sel_d <= 1'b1;
            st.oe_n <= 1'b1;
            st.mute_sy <= 2'h3;
            st.right_code <= SGC_GAIN_RESET;
            st.left_code <= SGC_GAIN_RESET;
            st.r_gnd <= 1'b1;
            st.l_gnd <= 1'b1;
        end
        else
            st <= next_st;
    end

    //////////////////////////////////////////////////////////////////
    sgc_zc_channel #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_right (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_code(st.right_code),
        .mute_req(st.mute_lat),
        .zc_en(st.zc_sy[1]), // R14
        .sign_in(right_sign), // R22
        .active_code(r_act)
    );

    sgc_zc_channel #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_left (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .target_code(st.left_code),
        .mute_req(st.mute_lat),
        .zc_en(st.zc_sy[1]),
        .sign_in(left_sign),
        .active_code(l_act)
    );

    assign serial_out = st.dout;
    assign serial_out_oe_n = st.oe_n;
    assign right_gain = st.r_out;
    assign left_gain = st.l_out;
    assign right_analog_ground = st.r_gnd;
    assign left_analog_ground = st.l_gnd;

    //////////////////////////////////////////////////////////////////
    sequence s_rise_sel;
        !st.sel_d ##1 st.sel_d;
    endsequence

    property p_oe;
        @(posedge mclk) disable iff (sys_rst) serial_out_oe_n == $past(sel_now);
    endproperty
    a_oe: assert property (p_oe) else $error("oe not following select"); // R05

    property p_load;
        @(posedge mclk) disable iff (sys_rst)
            s_rise_sel |=> st.right_code == $past(st.shreg[15:8], 2)
                && st.left_code == $past(st.shreg[7:0], 2);
    endproperty
    a_load: assert property (p_load) else $error("word not loaded"); // R20

    property p_nomid;
        @(posedge mclk) disable iff (sys_rst)
            !sel_now && !$past(sel_now) |=> $stable(st.right_code) && $stable(st.left_code);
    endproperty
    a_nomid: assert property (p_nomid) else $error("codes changed mid word"); // R20

    property p_shift;
        @(posedge mclk) disable iff (sys_rst)
            !sel_now && clk_rise |=> st.shreg[0] == $past(st.din_sy[1]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift failed"); // R04

    property p_idle;
        @(posedge mclk) disable iff (sys_rst)
            sel_now && !$past(sel_now) ##1 sel_now |-> $stable(st.shreg);
    endproperty
    a_idle: assert property (p_idle) else $error("shift while deselected"); // R01

    property p_dout;
        @(posedge mclk) disable iff (sys_rst)
            $changed(serial_out) |-> $past(clk_fall);
    endproperty
    a_dout: assert property (p_dout) else $error("output moved off falling edge"); // R06

    property p_gnd;
        @(posedge mclk) disable iff (sys_rst)
            right_analog_ground == ($past(r_act) == 8'h00);
    endproperty
    a_gnd: assert property (p_gnd) else $error("mute ground wrong"); // R11

    property p_mutewait;
        @(posedge mclk) disable iff (sys_rst)
            !sel_now && !st.mute_lat |=> !st.mute_lat;
    endproperty
    a_mutewait: assert property (p_mutewait) else $error("mute during select"); // R18

    property p_mutetake;
        @(posedge mclk) disable iff (sys_rst)
            sel_now && !st.mute_sy[1] |=> st.mute_lat;
    endproperty
    a_mutetake: assert property (p_mutetake) else $error("mute not taken"); // R15

    property p_mutefree;
        @(posedge mclk) disable iff (sys_rst)
            st.mute_sy[1] |=> !st.mute_lat;
    endproperty
    a_mutefree: assert property (p_mutefree) else $error("mute not released"); // R15

    // with gating off a held mute reaches both grounds two cycles later
    sequence s_mute_direct;
        st.mute_lat && !st.zc_sy[1];
    endsequence

    property p_mutegnd;
        @(posedge mclk) disable iff (sys_rst)
            s_mute_direct |-> ##2 (right_analog_ground && left_analog_ground);
    endproperty
    a_mutegnd: assert property (p_mutegnd) else $error("mute not applied"); // R18

    property p_gndl;
        @(posedge mclk) disable iff (sys_rst)
            left_analog_ground == ($past(l_act) == SGC_GAIN_MUTE);
    endproperty
    a_gndl: assert property (p_gndl) else $error("left mute ground wrong"); // R11

    property p_gain;
        @(posedge mclk) disable iff (sys_rst)
            right_gain == $past(r_act) && left_gain == $past(l_act);
    endproperty
    a_gain: assert property (p_gain) else $error("gain code not passed on"); // R12

    property p_codehold;
        @(posedge mclk) disable iff (sys_rst)
            !sel_rise |=> $stable(st.right_code) && $stable(st.left_code);
    endproperty
    a_codehold: assert property (p_codehold) else $error("codes moved without write"); // R09

    property p_noshift;
        @(posedge mclk) disable iff (sys_rst)
            sel_now |=> $stable(st.shreg);
    endproperty
    a_noshift: assert property (p_noshift) else $error("shift while deselected"); // R01

    property p_msbfirst;
        @(posedge mclk) disable iff (sys_rst)
            !sel_now && clk_rise |=> st.shreg[15:1] == $past(st.shreg[14:0]);
    endproperty
    a_msbfirst: assert property (p_msbfirst) else $error("shifter order wrong"); // R03

    property p_chain;
        @(posedge mclk) disable iff (sys_rst)
            !sel_now && clk_fall |=> serial_out == $past(st.shreg[SGC_WORD_BITS - 1]);
    endproperty
    a_chain: assert property (p_chain) else $error("chain bit wrong"); // R07

    property p_directr;
        @(posedge mclk) disable iff (sys_rst)
            !st.zc_sy[1] && !st.mute_lat
                |=> r_act == $past(st.right_code) && l_act == $past(st.left_code);
    endproperty
    a_directr: assert property (p_directr) else $error("ungated apply failed"); // R13

    property p_split;
        @(posedge mclk) disable iff (sys_rst)
            sel_rise |=> st.right_code == $past(st.shreg[SGC_RIGHT_MSB -: SGC_CODE_BITS])
                && st.left_code == $past(st.shreg[SGC_LEFT_MSB -: SGC_CODE_BITS]);
    endproperty
    a_split: assert property (p_split) else $error("byte split wrong"); // R21

    property p_reset;
        @(posedge mclk)
            sys_rst |=> right_gain == SGC_GAIN_RESET && left_gain == SGC_GAIN_RESET
                && right_analog_ground && left_analog_ground && serial_out_oe_n && !serial_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong"); // R08
endmodule
`default_nettype wire

// ### core/sgc_zc_channel.sv
// one channel's gain apply logic with zero-crossing and timeout
`timescale 1ns/1ns
`default_nettype none
module sgc_zc_channel
    import sgc_pkg::*;
#(
    parameter int TIMEOUT_CYC = SGC_ZC_TIMEOUT_CYC
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // control
    input wire logic [7:0] target_code,
    input wire logic mute_req,
    input wire logic zc_en,
    input wire logic sign_in,
    // result
    output logic [7:0] active_code
);
    // the compare needs at least one counting step before it fires
    if (TIMEOUT_CYC < 2)
    begin : g_tmo_chk
        $error("timeout too short");
    end

    typedef struct packed {
        logic [7:0] code;
        logic s1;
        logic s2;
        logic s3;
        logic [1:0] xings;
        logic [31:0] tmr;
    } sgc_zc_s;

    sgc_zc_s st, next_st;
    logic [7:0] want;
    logic xing;

    always_comb
    begin
        next_st = st;
        want = mute_req ? SGC_GAIN_MUTE : target_code; // R11 R18
        next_st.s1 = sign_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        xing = st.s2 ^ st.s3;
        if (want == st.code)
        begin
            next_st.xings = 2'h0;
            next_st.tmr = 32'h0;
        end
        else if (!zc_en)
            next_st.code = want; // R13 R17
        // a pending mute needs only the next crossing; a gain change needs two
        else if ((xing && (mute_req || st.xings == 2'(SGC_ZC_CROSSINGS - 1)))
                 || st.tmr == 32'(TIMEOUT_CYC - 1))
        begin
            next_st.code = want; // R17 R18
            next_st.xings = 2'h0;
            next_st.tmr = 32'h0;
        end
        else
        begin
            next_st.tmr = st.tmr + 32'h1; // R22
            if (xing)
                next_st.xings = st.xings + 2'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st <= '0;
            st.code <= SGC_GAIN_RESET; // R08
        end
        else
            st <= next_st;
    end

    assign active_code = st.code;

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
            $changed(active_code)
                |-> $past(mute_req) || $past(active_code) != $past(target_code);
    endproperty
    a_hold: assert property (p_hold) else $error("gain changed without cause"); // R09

    sequence s_direct_held;
        (!zc_en && !mute_req) ##1 (!zc_en && !mute_req && $stable(target_code));
    endsequence

    property p_direct;
        @(posedge mclk) disable iff (sys_rst)
            s_direct_held |=> active_code == $past(target_code, 2);
    endproperty
    a_direct: assert property (p_direct) else $error("direct apply failed"); // R17

    property p_tmo;
        @(posedge mclk) disable iff (sys_rst)
            st.tmr < 32'(TIMEOUT_CYC);
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout exceeded"); // R17

    property p_mutexing;
        @(posedge mclk) disable iff (sys_rst)
            zc_en && mute_req && xing |=> active_code == SGC_GAIN_MUTE;
    endproperty
    a_mutexing: assert property (p_mutexing) else $error("mute missed crossing"); // R18
endmodule
`default_nettype wire

// ### test/sgc_host.sv
// host model: drives the three-wire serial port of the gain block
`timescale 1ns/1ns
`default_nettype none
module sgc_host
(
    // serial port
    output logic sel_n,
    output logic shift_clk,
    output logic serial_in,
    // daisy-chain return
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    logic [15:0] echo;
    initial
    begin
        sel_n = 1'b1;
        shift_clk = 1'b0;
        serial_in = 1'b0;
        echo = 16'h0000;
    end
    // select leads the first rise with margin for the pin synchronisers
    task automatic frame_open();
    begin
        sel_n = 1'b0;
        #100;
    end
    endtask
    // link clock rests low between calls; 80 ns period while shifting
    task automatic shift_bits(input logic [31:0] bits, input int n);
    begin
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in = bits[i];
            #40 shift_clk = 1'b1;
            if (!serial_out_oe_n)
                echo = {echo[14:0], serial_out};
            #40 shift_clk = 1'b0;
        end
        // a released data line must not keep showing the last bit
        serial_in = ~serial_in;
    end
    endtask
    task automatic frame_close();
    begin
        #40 sel_n = 1'b1;
        #100;
    end
    endtask
endmodule
`default_nettype wire

// ### test/sgc_top_bench.sv
// bench: serial writes, daisy chain, zero-cross gating and mute
`timescale 1ns/1ns
`default_nettype none
module sgc_top_bench;
    import sgc_pkg::*;
    localparam int TMO = 50;
    logic mclk, sys_rst, zero_cross_enable, mute_n, right_sign, left_sign;
    logic sel_n, shift_clk, serial_in, serial_out, serial_out_oe_n;
    logic right_analog_ground, left_analog_ground;
    logic [7:0] right_gain, left_gain;
    int failures, checked;
    sgc_top #(.TIMEOUT_CYC(TMO)) dut (.mclk(mclk), .sys_rst(sys_rst), .sel_n(sel_n),
        .shift_clk(shift_clk), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .zero_cross_enable(zero_cross_enable),
        .mute_n(mute_n), .right_sign(right_sign), .left_sign(left_sign),
        .right_gain(right_gain), .left_gain(left_gain),
        .right_analog_ground(right_analog_ground), .left_analog_ground(left_analog_ground));
    sgc_host host (.sel_n(sel_n), .shift_clk(shift_clk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n));
    always #2 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
    begin
        $display("failures=%0d checked=%0d", failures, checked);
        if (failures == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task automatic settle(input int n);
    begin
        repeat (n) @(posedge mclk);
        #1;
    end
    endtask
    // gains follow after synchronisers and gating, so poll under a bound
    task automatic expect_out(input logic [7:0] r, input logic [7:0] l, input logic [1:0] g);
        int n;
    begin
        n = 0;
        while ({right_gain, left_gain, right_analog_ground, left_analog_ground} !== {r, l, g}
            && n < 300)
        begin
            settle(1);
            n++;
        end
        check({right_gain, left_gain}, {r, l});
        check({14'h0, right_analog_ground, left_analog_ground}, {14'h0, g});
        if (n == 300)
            complete_run();
    end
    endtask
    task automatic wr(input logic [15:0] w);
    begin
        host.frame_open();
        host.shift_bits({16'h0, w}, 16);
        host.frame_close();
        settle(1);
    end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        zero_cross_enable = 1'b0;
        mute_n = 1'b1;
        right_sign = 1'b0;
        left_sign = 1'b0;
        failures = 0;
        checked = 0;
        settle(2);
        sys_rst = 1'b0;
        check({right_gain, left_gain}, {SGC_GAIN_RESET, SGC_GAIN_RESET});
        check({13'h0, serial_out_oe_n, right_analog_ground, left_analog_ground}, 16'h7);
        settle(4);
        host.frame_open();
        check({15'h0, serial_out_oe_n}, 16'h0);
        host.shift_bits(32'h5a, 8);
        settle(8);
        check({right_gain, left_gain}, 16'h0000);
        host.shift_bits(32'hc3, 8);
        host.frame_close();
        expect_out(8'h5a, 8'hc3, 2'b00);
        check({15'h0, serial_out_oe_n}, 16'h1);
        host.shift_bits(32'hffff, 16);
        host.frame_open();
        host.frame_close();
        expect_out(8'h5a, 8'hc3, 2'b00);
        // two words in one frame: the first falls out of serial_out
        host.frame_open();
        host.shift_bits(32'h00ff817e, 32);
        check(host.echo, 16'h00ff);
        host.frame_close();
        expect_out(8'h81, 8'h7e, 2'b00);
        wr(16'h00ff);
        expect_out(8'h00, 8'hff, 2'b10);
        zero_cross_enable = 1'b1;
        wr(16'h4020);
        settle(4);
        check({right_gain, left_gain}, 16'h00ff);
        right_sign = 1'b1;
        settle(3);
        right_sign = 1'b0;
        expect_out(8'h40, 8'hff, 2'b00);
        expect_out(8'h40, 8'h20, 2'b00);
        zero_cross_enable = 1'b0;
        mute_n = 1'b0;
        settle(10);
        check({14'h0, right_analog_ground, left_analog_ground}, 16'h3);
        mute_n = 1'b1;
        expect_out(8'h40, 8'h20, 2'b00);
        host.frame_open();
        settle(1);
        mute_n = 1'b0;
        settle(10);
        check({14'h0, right_analog_ground, left_analog_ground}, 16'h0);
        host.shift_bits(32'h1122, 16);
        host.frame_close();
        settle(10);
        check({14'h0, right_analog_ground, left_analog_ground}, 16'h3);
        mute_n = 1'b1;
        expect_out(8'h11, 8'h22, 2'b00);
        // gated mute waits for one crossing, well inside the timeout
        zero_cross_enable = 1'b1;
        mute_n = 1'b0;
        settle(8);
        check({14'h0, right_analog_ground, left_analog_ground}, 16'h0);
        right_sign = 1'b1;
        left_sign = 1'b1;
        settle(8);
        check({right_gain, left_gain}, 16'h0000);
        check({14'h0, right_analog_ground, left_analog_ground}, 16'h3);
        mute_n = 1'b1;
        expect_out(8'h11, 8'h22, 2'b00);
        complete_run();
    end
endmodule
`default_nettype wire
